// ===== shared/exec_pkg.sv
`default_nettype none

package exec_pkg;

	// Data path widths.
	localparam int ACC_W     = 4;
	localparam int X_W       = 3;
	localparam int RAM_WORDS = 128;
	localparam int RAM_AW    = 7;
	localparam int R_LINES   = 16;
	localparam int PLA_IN_W  = 5;
	localparam int ADDR_W    = 4;
	localparam int DATA_W    = 8;

	// Fixed opcodes.
	localparam logic [7:0] OPC_STORE_ACC           = 8'h27;
	localparam logic [7:0] OPC_STORE_ACC_INC_Y     = 8'h20;
	localparam logic [7:0] OPC_STORE_ACC_CLEAR_ACC = 8'h04;
	localparam logic [7:0] OPC_ACC_TO_Y            = 8'h24;
	localparam logic [7:0] OPC_READ_INPUTS         = 8'h08;
	localparam logic [7:0] OPC_MEM_TO_ACC          = 8'h21;
	localparam logic [7:0] OPC_MEM_TO_Y            = 8'h22;
	localparam logic [7:0] OPC_Y_TO_ACC            = 8'h23;
	localparam logic [7:0] OPC_SWAP_MEM_ACC        = 8'h2E;
	localparam logic [7:0] OPC_COMPARE_Y_ACC       = 8'h02;
	localparam logic [7:0] OPC_SET_OUTPUT_LINE     = 8'h0D;
	localparam logic [7:0] OPC_LOAD_PLA_IN         = 8'h0A;

	// Opcodes with an operand field in the low bits.
	localparam logic [7:0] MASK_BIT_OP             = 8'hFC;
	localparam logic [7:0] MASK_CONST_OP           = 8'hF0;
	localparam logic [7:0] OPC_SET_RAM_BIT         = 8'h30;
	localparam logic [7:0] OPC_TEST_RAM_BIT        = 8'h38;
	localparam logic [7:0] OPC_CONST_TO_Y          = 8'h40;
	localparam logic [7:0] OPC_COMPARE_Y_CONST     = 8'h50;
	localparam logic [7:0] OPC_STORE_CONST_INC_Y   = 8'h60;

	// Register port map.
	localparam logic [3:0] REG_X_FILE  = 4'h0;
	localparam logic [3:0] REG_ACC_Y   = 4'h1;
	localparam logic [3:0] REG_FLAGS   = 4'h2;
	localparam logic [3:0] REG_R_LOW   = 4'h3;
	localparam logic [3:0] REG_R_HIGH  = 4'h4;
	localparam logic [3:0] REG_RAM_IDX = 4'h5;
	localparam logic [3:0] REG_RAM_VAL = 4'h6;

	// Reset values.
	localparam logic [2:0] RST_X      = 3'h0;
	localparam logic [3:0] RST_ACC    = 4'h0;
	localparam logic [3:0] RST_Y      = 4'h0;
	localparam logic       RST_STATUS = 1'b1;
	localparam logic       RST_TSEL   = 1'b0;
	localparam logic [4:0] RST_PLA_IN = 5'h00;

	typedef enum logic [4:0] {
		OP_NONE            = 5'b00000,
		OP_SET_RAM_BIT     = 5'b00001,
		OP_SET_OUTPUT_LINE = 5'b00010,
		OP_STORE_ACC       = 5'b00011,
		OP_STORE_ACC_INC_Y = 5'b00100,
		OP_STORE_ACC_CLR   = 5'b00101,
		OP_ACC_TO_Y        = 5'b00110,
		OP_TEST_RAM_BIT    = 5'b00111,
		OP_STORE_CONST_INC = 5'b01000,
		OP_CONST_TO_Y      = 5'b01001,
		OP_READ_INPUTS     = 5'b01010,
		OP_MEM_TO_ACC      = 5'b01011,
		OP_MEM_TO_Y        = 5'b01100,
		OP_Y_TO_ACC        = 5'b01101,
		OP_SWAP_MEM_ACC    = 5'b01110,
		OP_COMPARE_Y_ACC   = 5'b01111,
		OP_COMPARE_Y_CONST = 5'b10000,
		OP_LOAD_PLA_IN     = 5'b10001
	} op_t;

	typedef struct packed {
		logic [2:0] x;
		logic [3:0] acc;
		logic [3:0] y;
		logic       status;
		logic       tsel;
		logic [4:0] pla_in;
		logic [6:0] ram_idx;
		logic [7:0] rdata;
	} exec_state_t;

	// Operand fields sit bit-reversed in the low bits of the opcode.
	function automatic logic [1:0] bit_field(input logic [7:0] op);
		return {op[0], op[1]};
	endfunction

	function automatic logic [3:0] const_field(input logic [7:0] op);
		return {op[0], op[1], op[2], op[3]};
	endfunction

	function automatic op_t decode(input logic [7:0] op);
		op_t r;
		r = OP_NONE;
		unique case (1'b1)
			op == OPC_STORE_ACC:                            r = OP_STORE_ACC;
			op == OPC_STORE_ACC_INC_Y:                      r = OP_STORE_ACC_INC_Y;
			op == OPC_STORE_ACC_CLEAR_ACC:                  r = OP_STORE_ACC_CLR;
			op == OPC_ACC_TO_Y:                             r = OP_ACC_TO_Y;
			op == OPC_READ_INPUTS:                          r = OP_READ_INPUTS;
			op == OPC_MEM_TO_ACC:                           r = OP_MEM_TO_ACC;
			op == OPC_MEM_TO_Y:                             r = OP_MEM_TO_Y;
			op == OPC_Y_TO_ACC:                             r = OP_Y_TO_ACC;
			op == OPC_SWAP_MEM_ACC:                         r = OP_SWAP_MEM_ACC;
			op == OPC_COMPARE_Y_ACC:                        r = OP_COMPARE_Y_ACC;
			op == OPC_SET_OUTPUT_LINE:                      r = OP_SET_OUTPUT_LINE;
			op == OPC_LOAD_PLA_IN:                          r = OP_LOAD_PLA_IN;
			(op & MASK_BIT_OP) == OPC_SET_RAM_BIT:          r = OP_SET_RAM_BIT;
			(op & MASK_BIT_OP) == OPC_TEST_RAM_BIT:         r = OP_TEST_RAM_BIT;
			(op & MASK_CONST_OP) == OPC_CONST_TO_Y:         r = OP_CONST_TO_Y;
			(op & MASK_CONST_OP) == OPC_COMPARE_Y_CONST:    r = OP_COMPARE_Y_CONST;
			(op & MASK_CONST_OP) == OPC_STORE_CONST_INC_Y:  r = OP_STORE_CONST_INC;
			default:                                        r = OP_NONE;
		endcase
		return r;
	endfunction

endpackage

`default_nettype wire

// ===== hdl/exec_ram.sv
`timescale 1ns/1ps
`default_nettype none

// Data memory: eight files of sixteen four-bit words, held in flip-flops.
module exec_ram (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	// Instruction side
	input  wire logic [6:0] addr,
	input  wire logic       wr_en,
	input  wire logic [3:0] wr_data,
	output logic      [3:0] rd_data,
	// Software peek
	input  wire logic [6:0] peek_addr,
	output logic      [3:0] peek_data
);
	logic [exec_pkg::RAM_WORDS-1:0][3:0] mem_q;
	logic [exec_pkg::RAM_WORDS-1:0][3:0] mem_d;

	// Reads are combinational so a write and its read sit in one cycle.
	assign rd_data   = mem_q[addr];
	assign peek_data = mem_q[peek_addr];

	always_comb begin
		mem_d = mem_q;
		if (wr_en) begin
			mem_d[addr] = wr_data;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mem_q <= '0;
		end else begin
			mem_q <= mem_d;
		end
	end
endmodule

`default_nettype wire

// ===== hdl/out_line_latches.sv
`timescale 1ns/1ps
`default_nettype none

// Sixteen R output latches; only the indexed one changes on a set.
module out_line_latches (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	// Set request
	input  wire logic        set_en,
	input  wire logic [3:0]  sel,
	// Latch outputs
	output logic      [15:0] lines
);
	logic [exec_pkg::R_LINES-1:0] lines_q;
	logic [exec_pkg::R_LINES-1:0] lines_d;

	assign lines = lines_q;

	always_comb begin
		lines_d = lines_q;
		if (set_en) begin
			lines_d[sel] = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			lines_q <= '0;
		end else begin
			lines_q <= lines_d;
		end
	end
endmodule

`default_nettype wire

// ===== hdl/transfer_exec.sv
`timescale 1ns/1ps
`default_nettype none

module transfer_exec (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	// Instruction stream, one instruction per valid cycle
	input  wire logic [7:0]  instr,
	input  wire logic        instr_valid,
	// K input lines
	input  wire logic [3:0]  k_in,
	// Register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// Machine state
	output logic      [3:0]  acc,
	output logic      [3:0]  y_reg,
	output logic             status,
	output logic             term_select_latch,
	output logic      [4:0]  pla_input_register,
	output logic      [15:0] r_lines
);
	exec_pkg::exec_state_t st_q;
	exec_pkg::exec_state_t st_d;
	exec_pkg::op_t         op;
	logic [6:0]            ram_addr;
	logic [3:0]            ram_rd;
	logic [3:0]            ram_wr_data;
	logic                  ram_wr_en;
	logic [3:0]            peek_data;
	logic                  set_line;
	logic [1:0]            bsel;
	logic [3:0]            cfield;

	assign op       = instr_valid ? exec_pkg::decode(instr) : exec_pkg::OP_NONE;
	assign ram_addr = {st_q.x, st_q.y};
	assign bsel     = exec_pkg::bit_field(instr);
	assign cfield   = exec_pkg::const_field(instr);

	// RAM write path; read-modify-write for the bit op fits one cycle.
	always_comb begin
		ram_wr_en   = 1'b0;
		ram_wr_data = st_q.acc;
		unique case (op)
			exec_pkg::OP_SET_RAM_BIT: begin
				ram_wr_en   = 1'b1;
				ram_wr_data = ram_rd | (4'h1 << bsel);
			end
			exec_pkg::OP_STORE_ACC: begin
				ram_wr_en = 1'b1;
			end
			exec_pkg::OP_STORE_ACC_INC_Y: begin
				ram_wr_en = 1'b1;
			end
			exec_pkg::OP_STORE_ACC_CLR: begin
				ram_wr_en = 1'b1;
			end
			exec_pkg::OP_STORE_CONST_INC: begin
				ram_wr_en   = 1'b1;
				ram_wr_data = cfield;
			end
			exec_pkg::OP_SWAP_MEM_ACC: begin
				ram_wr_en = 1'b1;
			end
			default: begin
				ram_wr_en = 1'b0;
			end
		endcase
	end

	assign set_line = (op == exec_pkg::OP_SET_OUTPUT_LINE);

	always_comb begin
		st_d       = st_q;
		st_d.rdata = 8'h00;

		unique case (op)
			exec_pkg::OP_SET_RAM_BIT: begin
				st_d.status = 1'b1;
			end
			exec_pkg::OP_SET_OUTPUT_LINE: begin
				st_d.status = 1'b1;
			end
			exec_pkg::OP_STORE_ACC: begin
				st_d.status = 1'b1;
			end
			exec_pkg::OP_STORE_ACC_INC_Y: begin
				st_d.status = 1'b1;
			end
			exec_pkg::OP_STORE_ACC_CLR: begin
				st_d.status = 1'b1;
			end
			exec_pkg::OP_ACC_TO_Y: begin
				st_d.status = 1'b1;
			end
			exec_pkg::OP_STORE_CONST_INC: begin
				st_d.status = 1'b1;
			end
			exec_pkg::OP_CONST_TO_Y: begin
				st_d.status = 1'b1;
			end
			exec_pkg::OP_READ_INPUTS: begin
				st_d.status = 1'b1;
			end
			exec_pkg::OP_MEM_TO_ACC: begin
				st_d.status = 1'b1;
			end
			exec_pkg::OP_MEM_TO_Y: begin
				st_d.status = 1'b1;
			end
			exec_pkg::OP_Y_TO_ACC: begin
				st_d.status = 1'b1;
			end
			exec_pkg::OP_SWAP_MEM_ACC: begin
				st_d.status = 1'b1;
			end
			exec_pkg::OP_LOAD_PLA_IN: begin
				st_d.status = 1'b1;
			end
			exec_pkg::OP_TEST_RAM_BIT: begin
				st_d.status = ram_rd[bsel];
			end
			exec_pkg::OP_COMPARE_Y_ACC: begin
				st_d.status = (st_q.y != st_q.acc);
				st_d.tsel   = (st_q.y != st_q.acc);
			end
			exec_pkg::OP_COMPARE_Y_CONST: begin
				st_d.status = (st_q.y != cfield);
			end
			default: begin
				st_d.status = st_q.status;
			end
		endcase

		unique case (op)
			exec_pkg::OP_STORE_ACC_INC_Y: begin
				st_d.y = 4'(st_q.y + 4'h1);
			end
			exec_pkg::OP_STORE_CONST_INC: begin
				st_d.y = 4'(st_q.y + 4'h1);
			end
			exec_pkg::OP_STORE_ACC_CLR: begin
				st_d.acc = 4'h0;
			end
			exec_pkg::OP_ACC_TO_Y: begin
				st_d.y = st_q.acc;
			end
			exec_pkg::OP_CONST_TO_Y: begin
				st_d.y = cfield;
			end
			exec_pkg::OP_READ_INPUTS: begin
				st_d.acc = k_in;
			end
			exec_pkg::OP_MEM_TO_ACC: begin
				st_d.acc = ram_rd;
			end
			exec_pkg::OP_MEM_TO_Y: begin
				st_d.y = ram_rd;
			end
			exec_pkg::OP_Y_TO_ACC: begin
				st_d.acc = st_q.y;
			end
			exec_pkg::OP_SWAP_MEM_ACC: begin
				st_d.acc = ram_rd;
			end
			exec_pkg::OP_LOAD_PLA_IN: begin
				st_d.pla_in = {st_q.tsel, st_q.acc};
			end
			default: begin
				st_d.pla_in = st_q.pla_in;
			end
		endcase

		// Software may move X and the peek index; X belongs to other logic.
		if (reg_wr) begin
			unique case (reg_addr)
				exec_pkg::REG_X_FILE: begin
					st_d.x = reg_wdata[2:0];
				end
				exec_pkg::REG_RAM_IDX: begin
					st_d.ram_idx = reg_wdata[6:0];
				end
				default: begin
					st_d.x = st_d.x;
				end
			endcase
		end

		// Read data stands only in the cycle after the strobe.
		if (reg_rd) begin
			unique case (reg_addr)
				exec_pkg::REG_X_FILE:  st_d.rdata = {5'h00, st_q.x};
				exec_pkg::REG_ACC_Y:   st_d.rdata = {st_q.acc, st_q.y};
				exec_pkg::REG_FLAGS:   st_d.rdata = {1'b0, st_q.status, st_q.tsel, st_q.pla_in};
				exec_pkg::REG_R_LOW:   st_d.rdata = r_lines[7:0];
				exec_pkg::REG_R_HIGH:  st_d.rdata = r_lines[15:8];
				exec_pkg::REG_RAM_IDX: st_d.rdata = {1'b0, st_q.ram_idx};
				exec_pkg::REG_RAM_VAL: st_d.rdata = {4'h0, peek_data};
				default:               st_d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_q.x       <= exec_pkg::RST_X;
			st_q.acc     <= exec_pkg::RST_ACC;
			st_q.y       <= exec_pkg::RST_Y;
			st_q.status  <= exec_pkg::RST_STATUS;
			st_q.tsel    <= exec_pkg::RST_TSEL;
			st_q.pla_in  <= exec_pkg::RST_PLA_IN;
			st_q.ram_idx <= 7'h00;
			st_q.rdata   <= 8'h00;
		end else begin
			st_q <= st_d;
		end
	end

	exec_ram u_ram (
		.clk_sys   (clk_sys),
		.nrst      (nrst),
		.addr      (ram_addr),
		.wr_en     (ram_wr_en),
		.wr_data   (ram_wr_data),
		.rd_data   (ram_rd),
		.peek_addr (st_q.ram_idx),
		.peek_data (peek_data)
	);

	out_line_latches u_lines (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.set_en  (set_line),
		.sel     (st_q.y),
		.lines   (r_lines)
	);

	assign reg_rdata          = st_q.rdata;
	assign acc                = st_q.acc;
	assign y_reg              = st_q.y;
	assign status             = st_q.status;
	assign term_select_latch  = st_q.tsel;
	assign pla_input_register = st_q.pla_in;
endmodule

`default_nettype wire

// ===== testbench/exec_chk.sv
`timescale 1ns/1ps
`default_nettype none

module exec_chk (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        nrst,
	// Instruction side
	input wire logic [7:0]  instr,
	input wire logic        instr_valid,
	input wire logic [3:0]  k_in,
	// Machine state
	input wire logic [3:0]  acc,
	input wire logic [3:0]  y_reg,
	input wire logic        status,
	input wire logic        term_select_latch,
	input wire logic [4:0]  pla_input_register,
	input wire logic [15:0] r_lines
);
	logic [7:0] op;
	logic [3:0] cf;

	// An idle cycle reads as an opcode that decodes to nothing.
	assign op = instr_valid ? instr : 8'hFF;
	assign cf = {instr[0], instr[1], instr[2], instr[3]};

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	AST_ACC_TO_Y: assert property (op == exec_pkg::OPC_ACC_TO_Y |=>
		y_reg == $past(acc) && acc == $past(acc) && status) else $error("acc to y wrong");
	AST_Y_TO_ACC: assert property (op == exec_pkg::OPC_Y_TO_ACC |=>
		acc == $past(y_reg) && y_reg == $past(y_reg) && status) else $error("y to acc wrong");
	AST_READ_K: assert property (op == exec_pkg::OPC_READ_INPUTS |=>
		acc == $past(k_in) && status) else $error("k read wrong");
	AST_CLR_ACC: assert property (op == exec_pkg::OPC_STORE_ACC_CLEAR_ACC |=>
		acc == 4'h0 && status) else $error("acc not cleared");
	AST_INC_Y: assert property ((op == exec_pkg::OPC_STORE_ACC_INC_Y || op[7:4] == 4'h6) |=>
		y_reg == 4'($past(y_reg) + 4'h1) && status) else $error("y not incremented");
	AST_CONST_Y: assert property (op[7:4] == 4'h4 |=> y_reg == $past(cf) && status)
		else $error("const to y wrong");
	AST_CMP_CONST: assert property (op[7:4] == 4'h5 |=>
		status == ($past(y_reg) != $past(cf)) && $stable(y_reg)) else $error("y const compare wrong");
	AST_CMP_ACC: assert property (op == exec_pkg::OPC_COMPARE_Y_ACC |=>
		status == ($past(y_reg) != $past(acc)) && term_select_latch == status)
		else $error("y acc compare wrong");
	AST_LATCH_HOLD: assert property (op != exec_pkg::OPC_COMPARE_Y_ACC |=>
		$stable(term_select_latch)) else $error("select latch moved");
	AST_PLA_IN: assert property (op == exec_pkg::OPC_LOAD_PLA_IN |=>
		pla_input_register == {$past(term_select_latch), $past(acc)} && status)
		else $error("pla input register wrong");
	AST_SET_LINE: assert property (op == exec_pkg::OPC_SET_OUTPUT_LINE |=>
		r_lines == ($past(r_lines) | (16'h0001 << $past(y_reg))) && status)
		else $error("r line wrong");

	cover property (op == exec_pkg::OPC_COMPARE_Y_ACC ##1 term_select_latch);
	cover property (op[7:4] == 4'h5 ##1 !status);
	cover property (op == exec_pkg::OPC_READ_INPUTS && k_in != 4'h0);
endmodule

`default_nettype wire

// ===== testbench/keypad_model.sv
`timescale 1ns/1ps
`default_nettype none

// One keypad row scanned by a single R line; the return lines have pull-downs.
module keypad_model #(
	parameter int KEY_ROW = 3
) (
	// Key held down by the scenario
	input  wire logic [3:0]  key_code,
	// Scan lines from the block
	input  wire logic [15:0] r_lines,
	// Key return lines
	output logic      [3:0]  k_in
);
	// An unscanned row shows nothing, so stale key data cannot leak through.
	assign k_in = r_lines[KEY_ROW] ? key_code : 4'h0;
endmodule

`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	localparam int KEY_ROW = 3;
	logic        clk_sys = 1'b0;
	logic        nrst = 1'b0;
	logic [7:0]  instr = 8'h00;
	logic        instr_valid = 1'b0;
	logic [3:0]  key_code = 4'h0;
	logic [3:0]  reg_addr = 4'h0;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	wire  [3:0]  k_in;
	wire  [7:0]  reg_rdata;
	wire  [3:0]  acc;
	wire  [3:0]  y_reg;
	wire         status;
	wire         term_select_latch;
	wire  [4:0]  pla_input_register;
	wire  [15:0] r_lines;
	logic [2:0]  m_x = 3'h0;
	logic [3:0]  m_acc = 4'h0;
	logic [3:0]  m_y = 4'h0;
	logic        m_s = 1'b1;
	logic        m_ts = 1'b0;
	logic [4:0]  m_pl = 5'h00;
	logic [15:0] m_r = 16'h0000;
	logic [3:0]  m_ram [128];
	logic [30:0] q_st [$];
	logic [7:0]  q_rd [$];
	logic [7:0]  tab [17];
	logic [31:0] seed = 32'h7B0E;
	logic        tk_i = 1'b0;
	logic        tk_r = 1'b0;
	int          mismatches = 0;
	int          checked = 0;

	always #25 clk_sys = ~clk_sys;

	transfer_exec dut (.clk_sys, .nrst, .instr, .instr_valid, .k_in, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .acc, .y_reg, .status, .term_select_latch,
		.pla_input_register, .r_lines);

	keypad_model #(.KEY_ROW(KEY_ROW)) u_keys (.key_code, .r_lines, .k_in);

	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction

	task automatic stop_test();
		if (mismatches == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic cyc(input logic v, input logic [7:0] op, input logic w, input logic r,
		input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		instr <= op;
		instr_valid <= v;
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		cyc(1'b0, 8'h00, 1'b1, 1'b0, a, d);
		if (a == exec_pkg::REG_X_FILE)
			m_x = d[2:0];
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		cyc(1'b0, 8'h00, 1'b0, 1'b1, a, 8'h00);
		q_rd.push_back(e);
	endtask

	task automatic peek(input logic [6:0] i);
		wr(exec_pkg::REG_RAM_IDX, {1'b0, i});
		rd(exec_pkg::REG_RAM_VAL, {4'h0, m_ram[i]});
	endtask

	task automatic ex(input logic [7:0] op, input logic [3:0] kv);
		logic [6:0] a;
		logic [1:0] b;
		logic [3:0] c;
		logic [3:0] t;
		cyc(1'b1, op, 1'b0, 1'b0, 4'h0, 8'h00);
		key_code <= kv;
		a = {m_x, m_y};
		b = {op[0], op[1]};
		c = {op[0], op[1], op[2], op[3]};
		t = m_ram[a];
		m_s = 1'b1;
		casez (op)
			exec_pkg::OPC_STORE_ACC,
			exec_pkg::OPC_STORE_ACC_INC_Y,
			exec_pkg::OPC_STORE_ACC_CLEAR_ACC,
			exec_pkg::OPC_SWAP_MEM_ACC: m_ram[a] = m_acc;
			exec_pkg::OPC_ACC_TO_Y: m_y = m_acc;
			exec_pkg::OPC_READ_INPUTS: m_acc = m_r[KEY_ROW] ? kv : 4'h0;
			exec_pkg::OPC_MEM_TO_Y: m_y = t;
			exec_pkg::OPC_Y_TO_ACC: m_acc = m_y;
			exec_pkg::OPC_COMPARE_Y_ACC: m_s = (m_y != m_acc);
			exec_pkg::OPC_SET_OUTPUT_LINE: m_r[m_y] = 1'b1;
			exec_pkg::OPC_LOAD_PLA_IN: m_pl = {m_ts, m_acc};
			8'h3?: begin
				if (op[3])
					m_s = t[b];
				else
					m_ram[a][b] = 1'b1;
			end
			8'h4?: m_y = c;
			8'h5?: m_s = (m_y != c);
			8'h6?: m_ram[a] = c;
			default: ;
		endcase
		if (op == exec_pkg::OPC_COMPARE_Y_ACC)
			m_ts = m_s;
		if (op == exec_pkg::OPC_STORE_ACC_CLEAR_ACC)
			m_acc = 4'h0;
		if (op == exec_pkg::OPC_SWAP_MEM_ACC || op == exec_pkg::OPC_MEM_TO_ACC)
			m_acc = t;
		if (op == exec_pkg::OPC_STORE_ACC_INC_Y || op[7:4] == 4'h6)
			m_y = m_y + 4'h1;
		q_st.push_back({m_acc, m_y, m_s, m_ts, m_pl, m_r});
	endtask

	task automatic cmp_st(input logic [30:0] e);
		checked++;
		if ({acc, y_reg, status, term_select_latch, pla_input_register, r_lines} !== e) begin
			mismatches++;
			$display("FAIL %0t state differs, expected %h", $time, e);
		end
	endtask

	task automatic cmp_rd(input logic [7:0] e);
		checked++;
		if (reg_rdata !== e) begin
			mismatches++;
			$display("FAIL %0t read %h expected %h", $time, reg_rdata, e);
		end
	endtask

	always @(posedge clk_sys) begin
		tk_i <= instr_valid;
		tk_r <= reg_rd;
	end

	// Results are looked at mid-cycle, once the executing edge has settled.
	always @(negedge clk_sys) begin
		if (tk_i)
			cmp_st(q_st.pop_front());
		if (tk_r)
			cmp_rd(q_rd.pop_front());
		else
			cmp_rd(8'h00);
	end

	initial begin
		repeat (3000) @(posedge clk_sys);
		mismatches++;
		stop_test();
	end

	initial begin
		tab = '{8'h27, 8'h20, 8'h04, 8'h24, 8'h08, 8'h21, 8'h22, 8'h23, 8'h2E, 8'h02, 8'h0D,
			8'h0A, 8'h30, 8'h38, 8'h40, 8'h50, 8'h60};
		foreach (m_ram[i])
			m_ram[i] = 4'h0;
		repeat (10) @(posedge clk_sys);
		nrst <= 1'b1;
		wr(exec_pkg::REG_X_FILE, 8'h05);
		ex(8'h4C, 4'h0);
		ex(exec_pkg::OPC_SET_OUTPUT_LINE, 4'h0);
		ex(exec_pkg::OPC_READ_INPUTS, 4'h9);
		ex(exec_pkg::OPC_ACC_TO_Y, 4'h0);
		ex(exec_pkg::OPC_STORE_ACC_INC_Y, 4'h0);
		ex(exec_pkg::OPC_Y_TO_ACC, 4'h0);
		ex(8'h4F, 4'h0);
		ex(8'h65, 4'h0);
		ex(exec_pkg::OPC_STORE_ACC, 4'h0);
		ex(exec_pkg::OPC_STORE_ACC_CLEAR_ACC, 4'h0);
		ex(8'h4F, 4'h0);
		ex(exec_pkg::OPC_SWAP_MEM_ACC, 4'h0);
		ex(exec_pkg::OPC_MEM_TO_Y, 4'h0);
		ex(exec_pkg::OPC_MEM_TO_ACC, 4'h0);
		for (int b = 0; b < 4; b++) begin
			ex(exec_pkg::OPC_TEST_RAM_BIT | {6'h00, b[0], b[1]}, 4'h0);
			ex(exec_pkg::OPC_SET_RAM_BIT | {6'h00, b[0], b[1]}, 4'h0);
		end
		ex(exec_pkg::OPC_COMPARE_Y_ACC, 4'h0);
		ex(exec_pkg::OPC_LOAD_PLA_IN, 4'h0);
		rd(exec_pkg::REG_FLAGS, {1'b0, m_s, m_ts, m_pl});
		ex(exec_pkg::OPC_Y_TO_ACC, 4'h0);
		ex(exec_pkg::OPC_COMPARE_Y_ACC, 4'h0);
		ex(exec_pkg::OPC_LOAD_PLA_IN, 4'h0);
		ex(8'h50, 4'h0);
		ex(8'h58, 4'h0);
		rd(exec_pkg::REG_ACC_Y, {m_acc, m_y});
		rd(exec_pkg::REG_FLAGS, {1'b0, m_s, m_ts, m_pl});
		rd(exec_pkg::REG_X_FILE, {5'h00, m_x});
		rd(4'hF, 8'h00);
		for (int i = 0; i < 400; i++) begin
			seed = xs(seed);
			if (seed[20:18] == 3'h0)
				wr(exec_pkg::REG_X_FILE, seed[31:24]);
			ex(tab[seed % 17] | (seed[15:8] & ((seed % 17) < 12 ? 8'h00 :
				(seed % 17) < 14 ? 8'h03 : 8'h0F)), seed[27:24]);
		end
		rd(exec_pkg::REG_R_LOW, m_r[7:0]);
		rd(exec_pkg::REG_R_HIGH, m_r[15:8]);
		rd(exec_pkg::REG_FLAGS, {1'b0, m_s, m_ts, m_pl});
		for (int i = 0; i < 128; i++)
			peek(i[6:0]);
		rd(exec_pkg::REG_RAM_IDX, {1'b0, 7'h7F});
		cyc(1'b0, 8'h00, 1'b0, 1'b0, 4'h0, 8'h00);
		repeat (3) @(posedge clk_sys);
		stop_test();
	end
endmodule

bind transfer_exec exec_chk u_chk (.clk_sys, .nrst, .instr, .instr_valid, .k_in, .acc, .y_reg,
	.status, .term_select_latch, .pla_input_register, .r_lines);

`default_nettype wire
